// ### design/stx_exec.sv
// Execution unit for swap, skip, table read and XOR instructions.
// Assumes a decoded one-hot op pulse, memory read data valid with it, one clock.
// Functional notes
// - Swap-to-acc puts memory high nibble low, low nibble high; memory unchanged.
// - Skip-if-zero on zero byte discards prefetch, adds dummy cycle: 2 cycles.
// - Load-acc-skip-if-zero copies byte to accumulator, skips the same way if zero.
// - Skip-if-bit-clear squashes prefetch and adds dummy cycle when bit is zero.
// - Table read current page: low byte to memory, high part to latch, no flags.
// - Table read last page: same transfer using the last program page.
// - XOR into accumulator; memory unchanged.
// - XOR into memory; accumulator unchanged.
// - XOR immediate with accumulator, result to accumulator.
// - XOR variants change only the zero flag.
module stx_exec #(
  parameter int DATA_W = stx_pkg::DATA_W,
  parameter int ROM_W = stx_pkg::ROM_W,
  parameter int ROM_AW = stx_pkg::ROM_AW
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_op_valid,
  input wire stx_pkg::stx_op_t i_op,
  input wire logic [DATA_W-1:0] i_mem_rdata,
  input wire logic [DATA_W-1:0] i_imm,
  input wire logic [stx_pkg::BIT_SEL_W-1:0] i_bit_sel,
  input wire logic [DATA_W-1:0] i_table_pointer,
  input wire logic [ROM_AW-1:0] i_pc,
  input wire logic i_zero_flag,
  input wire logic [ROM_W-1:0] i_rom_rdata,
  output logic o_busy,
  output logic o_discard,
  output logic [ROM_AW-1:0] o_rom_addr,
  output logic o_rom_rd,
  output logic o_mem_we,
  output logic [DATA_W-1:0] o_mem_wdata,
  output logic [DATA_W-1:0] o_acc,
  output logic o_zero_flag_we,
  output logic o_zero_flag,
  output logic [stx_pkg::TBH_W-1:0] o_table_high_latch
);
  typedef struct packed {
    stx_pkg::stx_state_t st;
    logic [DATA_W-1:0] acc;
    logic [stx_pkg::TBH_W-1:0] tbh;
    logic discard;
    logic mem_we;
    logic [DATA_W-1:0] mem_wdata;
    logic zf_we;
    logic zf;
    logic [ROM_AW-1:0] rom_addr;
    logic rom_rd;
  } stx_regs_t;

  stx_regs_t s_r;
  stx_regs_t s_nxt;
  logic mem_zero;
  logic xor_zero;
  logic [DATA_W-1:0] xor_res;
  logic [DATA_W-1:0] xor_rhs;

  assign xor_rhs = (i_op == stx_pkg::OP_XOR_IMM) ? i_imm : i_mem_rdata;
  assign xor_res = s_r.acc ^ xor_rhs;

  stx_zero_det #(.WIDTH(DATA_W)) u_mem_zero (
    .i_val(i_mem_rdata),
    .o_zero(mem_zero)
  );
  stx_zero_det #(.WIDTH(DATA_W)) u_xor_zero (
    .i_val(xor_res),
    .o_zero(xor_zero)
  );

  always_comb begin
    s_nxt = s_r;
    s_nxt.discard = 1'b0;
    s_nxt.mem_we = 1'b0;
    s_nxt.zf_we = 1'b0;
    s_nxt.rom_rd = 1'b0;
    unique case (s_r.st)
      stx_pkg::ST_IDLE: begin
        if (i_op_valid) begin
          unique case (i_op)
            stx_pkg::OP_SWAP_ACC: begin
              s_nxt.acc = {i_mem_rdata[DATA_W/2-1:0], i_mem_rdata[DATA_W-1:DATA_W/2]};
            end
            stx_pkg::OP_SKIP_Z: begin
              if (mem_zero) begin
                s_nxt.discard = 1'b1;
                s_nxt.st = stx_pkg::ST_DUMMY;
              end
            end
            stx_pkg::OP_LDA_SKIPZ: begin
              s_nxt.acc = i_mem_rdata;
              if (mem_zero) begin
                s_nxt.discard = 1'b1;
                s_nxt.st = stx_pkg::ST_DUMMY;
              end
            end
            stx_pkg::OP_SKIP_BITZ: begin
              if (!i_mem_rdata[i_bit_sel]) begin
                s_nxt.discard = 1'b1;
                s_nxt.st = stx_pkg::ST_DUMMY;
              end
            end
            stx_pkg::OP_TBL_CUR: begin
              s_nxt.rom_addr = {i_pc[ROM_AW-1:stx_pkg::PAGE_AW], i_table_pointer};
              s_nxt.rom_rd = 1'b1;
              s_nxt.st = stx_pkg::ST_TBL;
            end
            stx_pkg::OP_TBL_LAST: begin
              s_nxt.rom_addr = {stx_pkg::LAST_PAGE, i_table_pointer};
              s_nxt.rom_rd = 1'b1;
              s_nxt.st = stx_pkg::ST_TBL;
            end
            stx_pkg::OP_XOR_ACC, stx_pkg::OP_XOR_IMM: begin
              s_nxt.acc = xor_res;
              s_nxt.zf_we = 1'b1;
              s_nxt.zf = xor_zero;
            end
            stx_pkg::OP_XOR_MEM: begin
              s_nxt.mem_we = 1'b1;
              s_nxt.mem_wdata = xor_res;
              s_nxt.zf_we = 1'b1;
              s_nxt.zf = xor_zero;
            end
            default: begin
            end
          endcase
        end
      end
      stx_pkg::ST_DUMMY: begin
        s_nxt.st = stx_pkg::ST_IDLE;
      end
      stx_pkg::ST_TBL: begin
        s_nxt.mem_we = 1'b1;
        s_nxt.mem_wdata = i_rom_rdata[DATA_W-1:0];
        s_nxt.tbh = i_rom_rdata[ROM_W-1:DATA_W];
        s_nxt.st = stx_pkg::ST_IDLE;
      end
      default: begin
        s_nxt.st = stx_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      s_r <= '{st: stx_pkg::ST_IDLE, acc: stx_pkg::ACC_RESET, tbh: stx_pkg::TBH_RESET,
               discard: 1'b0, mem_we: 1'b0, mem_wdata: stx_pkg::ZERO_BYTE, zf_we: 1'b0,
               zf: 1'b0, rom_addr: '0, rom_rd: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_busy = (s_r.st != stx_pkg::ST_IDLE);
  assign o_discard = s_r.discard;
  assign o_rom_addr = s_r.rom_addr;
  assign o_rom_rd = s_r.rom_rd;
  assign o_mem_we = s_r.mem_we;
  assign o_mem_wdata = s_r.mem_wdata;
  assign o_acc = s_r.acc;
  assign o_zero_flag_we = s_r.zf_we;
  assign o_zero_flag = s_r.zf_we ? s_r.zf : i_zero_flag;
  assign o_table_high_latch = s_r.tbh;

  chk_swap_nibbles: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_op_valid && !o_busy && i_op == stx_pkg::OP_SWAP_ACC)
      |=> (o_acc == {$past(i_mem_rdata[3:0]), $past(i_mem_rdata[7:4])} && !o_mem_we))
    else $error("swap result wrong");
  chk_skip_zero: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_op_valid && !o_busy && i_op == stx_pkg::OP_SKIP_Z)
      |=> ((o_discard == ($past(i_mem_rdata) == stx_pkg::ZERO_BYTE)) and (o_discard |-> (o_busy ##1 !o_busy))))
    else $error("skip on zero byte wrong");
  chk_discard_pulse: assert property (@(posedge i_mclk) disable iff (i_rst)
    o_discard |=> !o_discard)
    else $error("discard longer than one cycle");
  chk_dummy_cycle: assert property (@(posedge i_mclk) disable iff (i_rst)
    (o_busy && !o_rom_rd)
      |=> (!o_busy && !o_discard && !o_mem_we && !o_zero_flag_we && $stable(o_acc)))
    else $error("dummy cycle not idle");
  chk_load_skip: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_op_valid && !o_busy && i_op == stx_pkg::OP_LDA_SKIPZ)
      |=> (o_acc == $past(i_mem_rdata) && o_discard == (o_acc == 8'h00)))
    else $error("load and skip wrong");
  chk_bit_skip: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_op_valid && !o_busy && i_op == stx_pkg::OP_SKIP_BITZ)
      |=> o_discard == !$past(i_mem_rdata[i_bit_sel]))
    else $error("bit skip wrong");
  chk_tbl_cur: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_op_valid && !o_busy && i_op == stx_pkg::OP_TBL_CUR)
      |=> (o_rom_rd && o_rom_addr[7:0] == $past(i_table_pointer)) ##1
          (o_mem_we && o_mem_wdata == $past(i_rom_rdata[7:0]) && !o_zero_flag_we))
    else $error("table read current page wrong");
  chk_tbl_last: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_op_valid && !o_busy && i_op == stx_pkg::OP_TBL_LAST)
      |=> (o_rom_addr[ROM_AW-1:stx_pkg::PAGE_AW] == stx_pkg::LAST_PAGE) ##1
          (o_table_high_latch == $past(i_rom_rdata[ROM_W-1:DATA_W])))
    else $error("table read last page wrong");
  chk_tbl_quiet: assert property (@(posedge i_mclk) disable iff (i_rst)
    (o_busy && o_rom_rd)
      |=> (o_mem_we && !o_busy && !o_zero_flag_we && !o_discard && $stable(o_acc)))
    else $error("table transfer cycle wrong");
  chk_xor_acc: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_op_valid && !o_busy && i_op == stx_pkg::OP_XOR_ACC)
      |=> (o_acc == ($past(o_acc) ^ $past(i_mem_rdata)) && o_zero_flag_we && !o_mem_we))
    else $error("xor into accumulator wrong");
  chk_xor_imm: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_op_valid && !o_busy && i_op == stx_pkg::OP_XOR_IMM)
      |=> (o_acc == ($past(o_acc) ^ $past(i_imm)) && o_zero_flag_we && !o_mem_we))
    else $error("xor immediate wrong");
  chk_xor_mem: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_op_valid && !o_busy && i_op == stx_pkg::OP_XOR_MEM)
      |=> (o_mem_we && $stable(o_acc) && o_mem_wdata == (o_acc ^ $past(i_mem_rdata))))
    else $error("xor into memory wrong");
  chk_xor_zflag: assert property (@(posedge i_mclk) disable iff (i_rst)
    o_zero_flag_we |-> (o_zero_flag == ((o_mem_we ? o_mem_wdata : o_acc) == stx_pkg::ZERO_BYTE)))
    else $error("zero flag wrong");
  chk_flags_kept: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_op_valid && !o_busy && (i_op == stx_pkg::OP_SWAP_ACC || i_op == stx_pkg::OP_SKIP_Z ||
      i_op == stx_pkg::OP_LDA_SKIPZ || i_op == stx_pkg::OP_SKIP_BITZ))
      |=> !o_zero_flag_we)
    else $error("flag changed by non-xor op");
endmodule

// ### design/stx_pkg.sv
// Package for the skip, table-read and XOR execution block.
// Assumes one 10 MHz instruction clock and a core that decodes opcodes upstream.
package stx_pkg;
  localparam int DATA_W = 8;
  localparam int ROM_W = 14;
  localparam int ROM_AW = 10;
  localparam int PAGE_AW = 8;
  localparam int TBH_W = ROM_W - DATA_W;
  localparam int BIT_SEL_W = 3;
  localparam logic [ROM_AW-PAGE_AW-1:0] LAST_PAGE = 2'h3;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
  localparam logic [TBH_W-1:0] TBH_RESET = 6'h00;
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam int SKIP_CYCLES = 2;
  localparam int NOSKIP_CYCLES = 1;

  typedef enum logic [9:0] {
    OP_NONE      = 10'h001,
    OP_SWAP_ACC  = 10'h002,
    OP_SKIP_Z    = 10'h004,
    OP_LDA_SKIPZ = 10'h008,
    OP_SKIP_BITZ = 10'h010,
    OP_TBL_CUR   = 10'h020,
    OP_TBL_LAST  = 10'h040,
    OP_XOR_ACC   = 10'h080,
    OP_XOR_MEM   = 10'h100,
    OP_XOR_IMM   = 10'h200
  } stx_op_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_DUMMY = 3'h2,
    ST_TBL   = 3'h4
  } stx_state_t;
endpackage

// ### design/stx_zero_det.sv
// Zero detector used for skip tests and the zero flag.
// Assumes a purely combinational operand from the same clock domain.
module stx_zero_det #(
  parameter int WIDTH = 8
) (
  input wire logic [WIDTH-1:0] i_val,
  output logic o_zero
);
  assign o_zero = (i_val == '0);
endmodule

// ### verif/skip_table_xor_exec_tb_top.sv
// Testbench for the skip, table-read and XOR execution block.
// Assumes stx_exec and stx_pkg are compiled alongside; inputs change on falling edges.
module skip_table_xor_exec_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic i_op_valid = 1'b0;
  stx_pkg::stx_op_t i_op = stx_pkg::OP_NONE;
  logic [7:0] i_mem_rdata = 8'h00;
  logic [7:0] i_imm = 8'h00;
  logic [2:0] i_bit_sel = 3'h0;
  logic [7:0] i_table_pointer = 8'h00;
  logic [9:0] i_pc = 10'h000;
  logic i_zero_flag = 1'b1;
  logic [13:0] i_rom_rdata = 14'h0000;
  logic o_busy, o_discard, o_rom_rd, o_mem_we, o_zero_flag_we, o_zero_flag;
  logic [9:0] o_rom_addr;
  logic [7:0] o_mem_wdata, o_acc;
  logic [5:0] o_table_high_latch;
  int bad_count = 0;
  int n_compared = 0;

  stx_exec u_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_op_valid(i_op_valid), .i_op(i_op),
    .i_mem_rdata(i_mem_rdata), .i_imm(i_imm), .i_bit_sel(i_bit_sel), .i_table_pointer(i_table_pointer),
    .i_pc(i_pc), .i_zero_flag(i_zero_flag), .i_rom_rdata(i_rom_rdata), .o_busy(o_busy),
    .o_discard(o_discard), .o_rom_addr(o_rom_addr), .o_rom_rd(o_rom_rd), .o_mem_we(o_mem_we),
    .o_mem_wdata(o_mem_wdata), .o_acc(o_acc), .o_zero_flag_we(o_zero_flag_we),
    .o_zero_flag(o_zero_flag), .o_table_high_latch(o_table_high_latch));

  initial begin
    forever #50 i_mclk = ~i_mclk;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    if (bad_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Idle edge first, then one op taken; returns at the falling edge after
  task automatic issue(input stx_pkg::stx_op_t op, input logic [7:0] m);
    @(negedge i_mclk);
    i_op = op;
    i_mem_rdata = m;
    i_op_valid = 1'b1;
    @(negedge i_mclk);
    i_op_valid = 1'b0;
    i_op = stx_pkg::OP_NONE;
  endtask

  task automatic wait_idle();
    int n;
    for (n = 0; n < 4 && o_busy !== 1'b0; n++) @(negedge i_mclk);
    if (o_busy !== 1'b0) begin
      bad_count++;
      conclude();
    end
  endtask

  task automatic t_xor();
    i_imm = 8'hA5;
    issue(stx_pkg::OP_XOR_IMM, 8'hFF);
    chk({o_acc, 6'h00, o_zero_flag_we, o_zero_flag}, {8'hA5, 8'h02});
    issue(stx_pkg::OP_XOR_ACC, 8'hA5);
    chk({o_acc, 6'h00, o_mem_we, o_zero_flag}, {8'h00, 8'h01});
    issue(stx_pkg::OP_XOR_MEM, 8'h3C);
    chk({o_mem_wdata, o_acc}, {8'h3C, 8'h00});
    chk({o_mem_we, o_zero_flag_we, o_zero_flag, o_discard}, 16'h000C);
  endtask

  task automatic t_swap();
    issue(stx_pkg::OP_SWAP_ACC, 8'h3C);
    chk(o_acc, 16'h00C3);
    chk({o_mem_we, o_zero_flag_we, o_zero_flag, o_discard}, 16'h0002);
  endtask

  task automatic t_skip();
    int i;
    i_zero_flag = 1'b0;
    issue(stx_pkg::OP_SKIP_Z, 8'h00);
    chk({o_discard, o_busy, o_zero_flag_we}, 16'h0006);
    @(negedge i_mclk);
    chk({o_discard, o_busy}, 16'h0000);
    issue(stx_pkg::OP_SKIP_Z, 8'h01);
    chk({o_discard, o_busy}, 16'h0000);
    issue(stx_pkg::OP_LDA_SKIPZ, 8'h00);
    chk({o_acc, 5'h00, o_discard, o_zero_flag_we, o_zero_flag}, 16'h0004);
    wait_idle();
    issue(stx_pkg::OP_LDA_SKIPZ, 8'h5A);
    chk({o_acc, 6'h00, o_discard, o_zero_flag_we}, 16'h5A00);
    for (i = 0; i < 8; i++) begin
      i_bit_sel = i[2:0];
      issue(stx_pkg::OP_SKIP_BITZ, 8'hF0);
      chk({o_discard, o_zero_flag_we}, {14'h0000, i < 4, 1'b0});
      wait_idle();
    end
  endtask

  task automatic t_table(input stx_pkg::stx_op_t op, input logic [1:0] pg, input logic [13:0] w);
    i_pc = 10'h2C5;
    i_table_pointer = 8'h7E;
    issue(op, 8'h00);
    chk({o_rom_rd, o_busy, 4'h0, o_rom_addr}, {2'b11, 4'h0, pg, 8'h7E});
    i_rom_rdata = w;
    @(negedge i_mclk);
    chk({o_mem_we, o_zero_flag_we, o_table_high_latch, o_mem_wdata}, {2'b10, w});
    wait_idle();
  endtask

  initial begin
    repeat (12) @(negedge i_mclk);
    i_rst = 1'b0;
    t_xor();
    t_swap();
    t_skip();
    t_table(stx_pkg::OP_TBL_CUR, 2'h2, 14'h2A5B);
    t_table(stx_pkg::OP_TBL_LAST, 2'h3, 14'h15C4);
    conclude();
  end
endmodule
